// file: verif/alarm_source_model.sv
/*
  Model of the alarm detection side: turns one-cycle bench requests into
  trip pulses and holds the release condition of the five conditional classes bad for a while.
  Assumes the bench raises fire for one cycle and sets hold beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
module alarm_source_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bench requests
  input wire logic [rearm_pkg::NUM_ALARMS-1:0] fire,
  input wire logic [7:0] hold,
  // Toward the block
  output logic [rearm_pkg::NUM_ALARMS-1:0] trip_event,
  output logic link_ok,
  output logic overheat,
  output logic start_wait_zero,
  output logic [1:0] ext_alarm_pin
);
  import rearm_pkg::*;
  localparam int SRC [5] = '{A_LINK, A_EXT1, A_EXT2, A_OVERTEMP, A_START_LIM};
  logic [7:0] left [5];
  logic [NUM_ALARMS-1:0] fire_d0, fire_d1, fire_d2;

  // Detection trips only once its own settled view of a pin shows the fault,
  // so the trip trails the condition going bad by a few cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fire_d0 <= '0;
      fire_d1 <= '0;
      fire_d2 <= '0;
      trip_event <= '0;
    end else begin
      fire_d0 <= fire;
      fire_d1 <= fire_d0;
      fire_d2 <= fire_d1;
      trip_event <= fire_d2;
    end
  end

  // Condition turns bad at the request, ahead of the trip, recovers after hold cycles
  for (genvar g = 0; g < 5; g++) begin : g_cond
    always_ff @(posedge core_clk) begin
      if (rst)
        left[g] <= 8'h00;
      else if (fire[SRC[g]])
        left[g] <= hold;
      else if (left[g] != 8'h00)
        left[g] <= left[g] - 8'h01;
    end
  end

  assign link_ok = (left[0] == 8'h00);
  assign ext_alarm_pin = {left[2] != 8'h00, left[1] != 8'h00};
  assign overheat = (left[3] != 8'h00);
  assign start_wait_zero = (left[4] == 8'h00);
endmodule // alarm_source_model
`default_nettype wire

// file: verif/tb_alarm_autoreset_delay.sv
/*
  Self-checking bench for the alarm autoreset delay block.
  Assumes a 10-cycle tick and a 5-tick decay window set at the instance.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_autoreset_delay;
  import rearm_pkg::*;
  localparam int SC = 10;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ramp_done = 1'b1;
  logic manual_reset = 1'b0;
  logic [14:0] fire = 15'h0000;
  logic [7:0] hold = 8'h00;
  logic [15:0] rdata, v, v2;
  logic [14:0] trip_event, rearm_pulse, alarm_latched;
  logic link_ok, overheat, start_wait_zero, fb_soft_reset, rtu_en;
  logic [1:0] ext_alarm_pin, link_type;
  logic [16:0] onboard_baud;
  logic [7:0] onboard_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32474;
  int n;

  always #20 core_clk = ~core_clk;

  alarm_source_model u_alarm_source_model (.core_clk(core_clk), .rst(rst), .fire(fire),
    .hold(hold), .trip_event(trip_event), .link_ok(link_ok), .overheat(overheat),
    .start_wait_zero(start_wait_zero), .ext_alarm_pin(ext_alarm_pin));

  alarm_autoreset_delay #(.SEC_CYC(SC), .DECAY_S(5)) u_alarm_autoreset_delay (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trip_event(trip_event), .link_ok(link_ok), .overheat(overheat),
    .start_wait_zero(start_wait_zero), .ramp_done(ramp_done), .manual_reset(manual_reset),
    .ext_alarm_pin(ext_alarm_pin), .alarm_latched(alarm_latched), .rearm_pulse(rearm_pulse),
    .link_type(link_type), .fb_soft_reset(fb_soft_reset), .rtu_en(rtu_en),
    .onboard_baud(onboard_baud), .onboard_addr(onboard_addr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] exp_delay(input logic [15:0] x);
    return (x > 16'h0e10) ? 16'h0e10 : x;
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic fire_one(input int idx);
    @(posedge core_clk);
    fire <= 15'h0001 << idx;
    @(posedge core_clk);
    fire <= 15'h0000;
  endtask

  task automatic wait_rearm(input int idx, input int lim, output int cnt);
    cnt = 0;
    while (rearm_pulse[idx] !== 1'b1 && cnt < lim) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
  endtask

  // Set the delay, clear all latches and the attempt count, trip one alarm, then expect rearm within the delay window when ok is set, and no rearm otherwise
  task automatic run(input int idx, input int d, input int h, input bit ok);
    int m;
    wr_reg(8'(idx), 16'(d));
    @(posedge core_clk);
    manual_reset <= 1'b1;
    @(posedge core_clk);
    manual_reset <= 1'b0;
    hold <= 8'(h);
    fire_one(idx);
    wait_rearm(idx, h + d * SC + 40, m);
    check(rearm_pulse[idx], ok);
    check(alarm_latched[idx], !ok);
    if (ok)
      check(m >= h + (d - 1) * SC - 2 && m <= h + d * SC + 12, 1'b1);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(onboard_baud, 17'h02580);
    check(onboard_addr, 8'h01);
    check(link_type, LINK_SERIAL);
    for (int i = 0; i < 15; i++) begin
      rd_reg(8'(i), v);
      check(v, DELAY_OFF);
    end
    rd_reg(8'h20, v);
    check(v, 16'h0000);
    wr_reg(REG_ATTEMPT_LIMIT, 16'h000a);
    // Conditional classes hold their release condition bad for 20 cycles
    for (int i = 0; i < 15; i++)
      run(i, 1 + ($unsigned($random(seed)) % 3),
          (i inside {A_LINK, A_EXT1, A_EXT2, A_OVERTEMP, A_START_LIM}) ? 20 : 0,
          1'b1);
    run(A_LOAD_LO, 1, 0, 1'b1);
    rd_reg(REG_ATTEMPT_COUNT, v);
    check(v, 16'h0001);
    wr_reg(REG_ATTEMPT_COUNT, 16'h0005);
    repeat (120) @(posedge core_clk);
    rd_reg(REG_ATTEMPT_COUNT, v);
    check(v, 16'h0000);
    run(A_LOAD_HI, 0, 0, 1'b0);
    wr_reg(REG_ATTEMPT_LIMIT, 16'h0000);
    run(A_LOAD_HI, 2, 0, 1'b0);
    wr_reg(REG_ATTEMPT_LIMIT, 16'h000a);
    ramp_done <= 1'b0;
    run(A_LOAD_HI, 1, 0, 1'b0);
    @(posedge core_clk);
    ramp_done <= 1'b1;
    wait_rearm(A_LOAD_HI, 6, n);
    check(rearm_pulse[A_LOAD_HI], 1'b1);
    // A repeat trip mid-count restarts the delay
    wr_reg(8'(A_LOAD_LO), 16'h0003);
    fire_one(A_LOAD_LO);
    repeat (14) @(posedge core_clk);
    fire_one(A_LOAD_LO);
    wait_rearm(A_LOAD_LO, 60, n);
    check(n >= 24 && rearm_pulse[A_LOAD_LO] === 1'b1, 1'b1);
    wr_reg(REG_LINK_TYPE, {14'h0000, LINK_RTU});
    @(posedge core_clk);
    #1;
    check(rtu_en, 1'b1);
    wr_reg(REG_LINK_TYPE, 16'h0003);
    rd_reg(REG_LINK_TYPE, v);
    check(v, 16'h0002);
    wr_reg(REG_LINK_TYPE, 16'h0000);
    #1;
    check(fb_soft_reset, 1'b0);
    wr_reg(REG_LINK_TYPE, {14'h0000, LINK_FIELDBUS});
    wr_reg(REG_LINK_TYPE, 16'h0000);
    #1;
    check(fb_soft_reset, 1'b1);
    @(posedge core_clk);
    #1;
    check(fb_soft_reset, 1'b0);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 16'h0e10 : (k == 1) ? 16'h0e11 : 16'($random(seed));
      wr_reg(8'(A_PHASE), v);
      rd_reg(8'(A_PHASE), v2);
      check(v2, exp_delay(v));
    end
    print_verdict();
  end
endmodule // tb_alarm_autoreset_delay
`default_nettype wire

// file: verilog/alarm_autoreset_delay.sv
/*
  Per-alarm autoreset delay timers, attempt counter with slow decay, and the
  link-type selector with its fieldbus soft reset.
  Assumes trip pulses and condition levels come from logic on core_clk;
  external alarm inputs are asynchronous pins.
*/
// Function
// RL1: Delay defaults off; 1..3600 seconds
// RL2: Stall delay starts after alarm action
// RL3: Current-limit delay starts after alarm action
// RL4: Link-loss delay starts when link returns
// RL5: Autoreset waits for ramp time expiry
// RL6: Load monitor delays start immediately
// RL7: External alarm delays start when input inactive
// RL8: Overtemp delay starts after unit cools
// RL9: Start-limit delay starts at wait zero
// RL10: Phase-loss delay starts after alarm action
// RL11: Supply alarms start after alarm action
// RL12: Expired delay clears its alarm
// RL13: Link type 0 serial, 1 fieldbus, 2 RTU
// RL14: Fieldbus to serial issues fieldbus soft reset
// RL15: Onboard port fixed 9600 baud, address 1
// RL16: RTU link type enables Modbus RTU
// RL17: Software selects fieldbus when module fitted
// RL18: Autoreset only within nonzero attempt allowance
// RL19: Attempt count decays every ten minutes
// RL20: One-second tick; recurring alarm restarts count
`timescale 1ns/1ps
`default_nettype none
module alarm_autoreset_delay
  import rearm_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int DECAY_S = DECAY_SECS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [rearm_pkg::ADDR_W-1:0] addr,
  input wire logic [rearm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rearm_pkg::DATA_W-1:0] rdata,
  // Alarm detection side
  input wire logic [rearm_pkg::NUM_ALARMS-1:0] trip_event,
  input wire logic link_ok,
  input wire logic overheat,
  input wire logic start_wait_zero,
  input wire logic ramp_done,
  input wire logic manual_reset,
  input wire logic [1:0] ext_alarm_pin,
  // Results
  output logic [rearm_pkg::NUM_ALARMS-1:0] alarm_latched,
  output logic [rearm_pkg::NUM_ALARMS-1:0] rearm_pulse,
  output logic [1:0] link_type,
  output logic fb_soft_reset,
  output logic rtu_en,
  output logic [16:0] onboard_baud,
  output logic [7:0] onboard_addr
);
  localparam int TW = $clog2(SEC_CYC + 1);
  localparam int DW = $clog2(DECAY_S + 1);

  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [DW-1:0] decay_cnt;
  logic [1:0] ext_q0, ext_q1, ext_q2;
  logic [1:0] ext_stable;
  logic [NUM_ALARMS-1:0] arm, running, expired, clear_now, setting_nz;
  logic [DLY_W-1:0] delay_set [NUM_ALARMS];
  logic [DLY_W-1:0] dly_cnt [NUM_ALARMS];
  logic [3:0] attempt_limit;
  logic [3:0] attempts;
  logic allow;

  // ----------------------------------------------------------------
  // One-second timebase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TW'(SEC_CYC - 1)) begin // RL20
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // External alarm pin synchroniser
  // ----------------------------------------------------------------
  // Only the settled value is used so a pin glitch cannot start a count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_q0 <= '0;
      ext_q1 <= '0;
      ext_q2 <= '0;
      ext_stable <= 2'h0;
    end else begin
      ext_q0 <= ext_alarm_pin;
      ext_q1 <= ext_q0;
      ext_q2 <= ext_q1;
      if (ext_q1[0] == ext_q2[0]) ext_stable[0] <= ext_q2[0];
      if (ext_q1[1] == ext_q2[1]) ext_stable[1] <= ext_q2[1];
    end
  end

  // ----------------------------------------------------------------
  // Start conditions per alarm class
  // ----------------------------------------------------------------
  always_comb begin
    // Stall, current limit, load monitor and supply alarms start at once
    arm = '1; // RL2 RL3 RL6 RL10 RL11
    arm[A_LINK] = link_ok; // RL4
    arm[A_EXT1] = ~ext_stable[0]; // RL7
    arm[A_EXT2] = ~ext_stable[1]; // RL7
    arm[A_OVERTEMP] = ~overheat; // RL8
    arm[A_START_LIM] = start_wait_zero; // RL9
  end

  assign allow = (attempt_limit != 4'h0) && (attempts <= attempt_limit); // RL18

  // ----------------------------------------------------------------
  // Per-alarm settings, delay counters and latches
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_alarm
      assign setting_nz[gi] = delay_set[gi] != DELAY_OFF;
      // The ramp must be over, and the delay still on, before a reset goes out
      assign clear_now[gi] = expired[gi] && alarm_latched[gi] && setting_nz[gi]
        && ramp_done && allow; // RL5 RL12

      always_ff @(posedge core_clk) begin
        if (rst) begin
          delay_set[gi] <= DELAY_OFF; // RL1
        end else if (wr && addr == REG_DELAY_BASE + 8'(gi)) begin
          // Out-of-range values saturate at the longest delay
          delay_set[gi] <= (wdata > 16'(DELAY_MAX)) ? DELAY_MAX : wdata[DLY_W-1:0]; // RL1
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          running[gi] <= 1'b0;
          expired[gi] <= 1'b0;
          dly_cnt[gi] <= '0;
        end else if (trip_event[gi] || !alarm_latched[gi]) begin
          running[gi] <= 1'b0; // RL20
          expired[gi] <= 1'b0;
          dly_cnt[gi] <= '0;
        end else if (!running[gi] && !expired[gi] && arm[gi] && setting_nz[gi]) begin
          running[gi] <= 1'b1;
          dly_cnt[gi] <= '0;
        end else if (running[gi] && tick) begin
          if (dly_cnt[gi] + 1'b1 >= delay_set[gi]) begin // RL12
            running[gi] <= 1'b0;
            expired[gi] <= 1'b1;
          end
          dly_cnt[gi] <= dly_cnt[gi] + 1'b1;
        end
      end

      // A new trip in the same cycle as a clear keeps the alarm latched
      always_ff @(posedge core_clk) begin
        if (rst) begin
          alarm_latched[gi] <= 1'b0;
          rearm_pulse[gi] <= 1'b0;
        end else begin
          rearm_pulse[gi] <= clear_now[gi] && !trip_event[gi]; // RL12
          if (trip_event[gi]) alarm_latched[gi] <= 1'b1;
          else if (clear_now[gi] || manual_reset) alarm_latched[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Attempt allowance and counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      attempt_limit <= 4'h0; // RL18
    end else if (wr && addr == REG_ATTEMPT_LIMIT) begin
      attempt_limit <= (wdata > 16'(LIMIT_MAX)) ? LIMIT_MAX : wdata[3:0];
    end
  end

  // Trips win over the decay step; a manual reset zeroes the count
  always_ff @(posedge core_clk) begin
    if (rst || manual_reset) begin
      attempts <= 4'h0;
      decay_cnt <= '0;
    end else if (trip_event != '0) begin
      decay_cnt <= '0;
      if (attempts != ATTEMPT_SAT) attempts <= attempts + 1'b1;
    end else if (tick) begin
      if (decay_cnt == DW'(DECAY_S - 1)) begin // RL19
        decay_cnt <= '0;
        if (attempts != 4'h0) attempts <= attempts - 1'b1;
      end else begin
        decay_cnt <= decay_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link type selector and serial port settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_type <= LINK_SERIAL; // RL13
      fb_soft_reset <= 1'b0;
      rtu_en <= 1'b0;
      onboard_baud <= ONBOARD_BAUD;
      onboard_addr <= ONBOARD_ADDR;
    end else begin
      fb_soft_reset <= 1'b0;
      rtu_en <= link_type == LINK_RTU; // RL16
      onboard_baud <= ONBOARD_BAUD; // RL15
      onboard_addr <= ONBOARD_ADDR; // RL15
      // Code 3 is undefined and leaves the selector unchanged
      if (wr && addr == REG_LINK_TYPE && wdata[1:0] <= LINK_RTU && wdata[15:2] == '0) begin
        link_type <= wdata[1:0]; // RL13
        fb_soft_reset <= link_type == LINK_FIELDBUS && wdata[1:0] == LINK_SERIAL; // RL14
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || !rd) begin
      rdata <= '0;
    end else if (addr < REG_DELAY_BASE + 8'(NUM_ALARMS)) begin
      rdata <= 16'(delay_set[addr[3:0]]);
    end else if (addr == REG_ATTEMPT_LIMIT) begin
      rdata <= 16'(attempt_limit);
    end else if (addr == REG_ATTEMPT_COUNT) begin
      rdata <= 16'(attempts);
    end else if (addr == REG_LINK_TYPE) begin
      rdata <= 16'(link_type);
    end else if (addr == REG_LATCHED) begin
      rdata <= 16'(alarm_latched);
    end else if (addr == REG_RUNNING) begin
      rdata <= 16'(running);
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_off_never_rearms;
    @(posedge core_clk) disable iff (rst)
      (rearm_pulse & ~$past(setting_nz)) == '0;
  endproperty
  a_off_never_rearms: assert property (p_off_never_rearms) // RL1
    else $error("rearm with delay off");

  property p_ramp_gate;
    @(posedge core_clk) disable iff (rst)
      rearm_pulse != '0 |-> $past(ramp_done);
  endproperty
  a_ramp_gate: assert property (p_ramp_gate) // RL5
    else $error("rearm before ramp done");

  property p_allowance;
    @(posedge core_clk) disable iff (rst)
      rearm_pulse != '0 |-> $past(attempt_limit) != 4'h0 && $past(attempts) <= $past(attempt_limit);
  endproperty
  a_allowance: assert property (p_allowance) // RL18
    else $error("rearm beyond allowance");

  property p_rearm_clears;
    @(posedge core_clk) disable iff (rst)
      rearm_pulse[A_STALL] |-> !alarm_latched[A_STALL] && $past(alarm_latched[A_STALL]);
  endproperty
  a_rearm_clears: assert property (p_rearm_clears) // RL12
    else $error("rearm did not clear alarm");

  property p_fb_reset;
    @(posedge core_clk) disable iff (rst)
      wr && addr == REG_LINK_TYPE && wdata == 16'h0000 && link_type == LINK_FIELDBUS
      |=> fb_soft_reset ##1 !fb_soft_reset;
  endproperty
  a_fb_reset: assert property (p_fb_reset) // RL14
    else $error("no fieldbus soft reset");

  property p_link_range;
    @(posedge core_clk) disable iff (rst)
      link_type <= LINK_RTU && rtu_en == ($past(link_type) == LINK_RTU);
  endproperty
  a_link_range: assert property (p_link_range) // RL13 RL16
    else $error("link type out of range");

  property p_onboard;
    @(posedge core_clk) disable iff (rst)
      onboard_addr == 8'h01 && onboard_baud == 17'h02580;
  endproperty
  a_onboard: assert property (p_onboard) // RL15
    else $error("onboard port not fixed");

  property p_restart;
    @(posedge core_clk) disable iff (rst)
      trip_event[A_LOAD_HI] |=> dly_cnt[A_LOAD_HI] == '0 && !expired[A_LOAD_HI];
  endproperty
  a_restart: assert property (p_restart) // RL20
    else $error("count not restarted");

  property p_ext_start;
    @(posedge core_clk) disable iff (rst)
      $rose(running[A_EXT1]) |-> $past(!ext_stable[0]);
  endproperty
  a_ext_start: assert property (p_ext_start) // RL7
    else $error("ext delay started while active");

  property p_link_start;
    @(posedge core_clk) disable iff (rst)
      $rose(running[A_LINK]) |-> $past(link_ok);
  endproperty
  a_link_start: assert property (p_link_start) // RL4
    else $error("link delay started without link");

  property p_decay;
    @(posedge core_clk) disable iff (rst || manual_reset)
      tick && decay_cnt == DW'(DECAY_S - 1) && trip_event == '0 && attempts != 4'h0
      |=> attempts == $past(attempts) - 4'h1;
  endproperty
  a_decay: assert property (p_decay) // RL19
    else $error("attempt count did not decay");
endmodule // alarm_autoreset_delay
`default_nettype wire

// file: verilog/rearm_pkg.sv
/*
  Constants for the alarm autoreset delay block: alarm indices, register
  offsets, field limits, encodings and timing counts.
  Assumes a 25 MHz core clock.
*/
`default_nettype none
package rearm_pkg;
  localparam int NUM_ALARMS = 15;
  localparam int DLY_W = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Alarm indices
  localparam int A_STALL = 0;
  localparam int A_CURLIM = 1;
  localparam int A_LINK = 2;
  localparam int A_LOAD_HI = 3;
  localparam int A_LOAD_HI_WARN = 4;
  localparam int A_LOAD_LO_WARN = 5;
  localparam int A_LOAD_LO = 6;
  localparam int A_EXT1 = 7;
  localparam int A_EXT2 = 8;
  localparam int A_OVERTEMP = 9;
  localparam int A_START_LIM = 10;
  localparam int A_PHASE = 11;
  localparam int A_UNBAL = 12;
  localparam int A_OVERV = 13;
  localparam int A_UNDERV = 14;
  // Register offsets; delay settings sit at offsets 0x00..0x0e by alarm index
  localparam logic [7:0] REG_DELAY_BASE = 8'h00;
  localparam logic [7:0] REG_ATTEMPT_LIMIT = 8'h10;
  localparam logic [7:0] REG_ATTEMPT_COUNT = 8'h11;
  localparam logic [7:0] REG_LINK_TYPE = 8'h12;
  localparam logic [7:0] REG_LATCHED = 8'h13;
  localparam logic [7:0] REG_RUNNING = 8'h14;
  // Field limits and resets
  localparam logic [11:0] DELAY_OFF = 12'h000;
  localparam logic [11:0] DELAY_MAX = 12'he10;
  localparam logic [3:0] LIMIT_MAX = 4'ha;
  localparam logic [3:0] ATTEMPT_SAT = 4'hf;
  // Link type encodings
  localparam logic [1:0] LINK_SERIAL = 2'h0;
  localparam logic [1:0] LINK_FIELDBUS = 2'h1;
  localparam logic [1:0] LINK_RTU = 2'h2;
  // Fixed on-board port settings
  localparam logic [16:0] ONBOARD_BAUD = 17'h02580;
  localparam logic [7:0] ONBOARD_ADDR = 8'h01;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int DECAY_MIN = 10;
  localparam int DECAY_SECS = DECAY_MIN * 60;
endpackage
`default_nettype wire
